// *** design/cpu_instruction_execution.sv ***
// register file, operation sequencing and interrupt/wait handling of the execution block
`timescale 1ns/1ps
module cpu_instruction_execution
  import cpu_exec_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              op_valid,
  input  cpu_exec_pkg::op_t      op_code,
  input  cpu_exec_pkg::ea_mode_t ea_mode,
  input  wire logic [1:0]        idx_sel,
  input  wire logic [7:0]        post_byte,
  input  wire logic [15:0]       operand,
  input  wire logic [15:0]       mem_data,
  input  wire logic              sbc_sel_b,
  input  wire logic              irq_n,
  input  wire logic              fast_interrupt_request_n,
  output logic [7:0]             acc_a_r,
  output logic [7:0]             acc_b_r,
  output logic [7:0]             condition_code_register,
  output logic [7:0]             direct_page_register,
  output logic [15:0]            x_r,
  output logic [15:0]            y_r,
  output logic [15:0]            u_r,
  output logic [15:0]            s_r,
  output logic [15:0]            pc_r,
  output logic [15:0]            ea_r,
  output logic [15:0]            fetch_addr_r,
  output logic                   masked_fetch_r,
  output logic                   int_take_r,
  output logic                   resume_next_r,
  output logic                   waiting,
  output logic                   xfer_reject_r,
  output logic [7:0]             push_select_r,
  output logic [15:0]            push_sp_value_r,
  output logic                   push_busy_r
);
  import cpu_exec_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic code_ok(input logic [3:0] c);
    code_ok = (c <= RC_PC) || ((c >= RC_A) && (c <= RC_DP));
  endfunction : code_ok

  function automatic logic [15:0] reg_read(input logic [3:0] c,
                                           input logic [15:0] d, x, y, u, s, pc,
                                           input logic [7:0] cc, dp);
    case (c)
      RC_D:    reg_read = d;
      RC_X:    reg_read = x;
      RC_Y:    reg_read = y;
      RC_U:    reg_read = u;
      RC_S:    reg_read = s;
      RC_PC:   reg_read = pc;
      RC_A:    reg_read = {8'h00, d[15:8]};
      RC_B:    reg_read = {8'h00, d[7:0]};
      RC_CC:   reg_read = {8'h00, cc};
      RC_DP:   reg_read = {8'h00, dp};
      default: reg_read = 16'h0000;
    endcase
  endfunction : reg_read

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic [3:0]  src_code = post_byte[7:4];
  wire logic [3:0]  dst_code = post_byte[3:0];
  wire logic        swap_op  = (op_code == OP_SWAP);
  wire logic        xfer_op  = op_valid && (swap_op || op_code == OP_COPY);
  wire logic        size_ok  = (src_code[RC_SIZE_BIT] == dst_code[RC_SIZE_BIT]);
  wire logic        xfer_ok  = code_ok(src_code) && code_ok(dst_code) && size_ok;
  wire logic        xfer_go  = xfer_op && xfer_ok && !waiting;
  wire logic [15:0] d_val    = {acc_a_r, acc_b_r};
  wire logic [15:0] src_val  = reg_read(src_code, d_val, x_r, y_r, u_r, s_r, pc_r,
                                        condition_code_register, direct_page_register);
  wire logic [15:0] dst_val  = reg_read(dst_code, d_val, x_r, y_r, u_r, s_r, pc_r,
                                        condition_code_register, direct_page_register);
  wire logic        run_op   = op_valid && !waiting;
  wire logic        ea_op    = run_op && (op_code == OP_EA);
  wire logic        alu_op   = run_op && (op_code inside {OP_MUL, OP_SEX, OP_ABX,
                                                          OP_DAA, OP_SBC, OP_COMPARE_DOUBLE_ACCUMULATOR_OP});
  wire logic        auto_mod = ea_mode inside {EA_INC1, EA_INC2, EA_DEC1, EA_DEC2};
  wire logic [15:0] idx_val  = (idx_sel == IX_X) ? x_r :
                               (idx_sel == IX_Y) ? y_r :
                               (idx_sel == IX_U) ? u_r : s_r;

  // next value of register k after a swap or copy
  function automatic logic [15:0] put(input logic [3:0] k, input logic [15:0] cur);
    if (xfer_go && dst_code == k) put = src_val;
    else if (xfer_go && swap_op && src_code == k) put = dst_val;
    else put = cur;
  endfunction : put

  logic [15:0] ea_calc;
  logic [15:0] idx_new;
  logic [7:0]  alu_a, alu_b, alu_cc;
  logic [15:0] alu_x;

  ea_unit ea_unit_inst (
    .mode      (ea_mode),
    .index     (idx_val),
    .acc_a     (acc_a_r),
    .acc_b     (acc_b_r),
    .pc        (pc_r),
    .dp        (direct_page_register),
    .operand   (operand),
    .ea        (ea_calc),
    .index_new (idx_new)
  );

  acc_alu acc_alu_inst (
    .op     (op_code),
    .a      (acc_a_r),
    .b      (acc_b_r),
    .x      (x_r),
    .cc     (condition_code_register),
    .mem    (mem_data),
    .sel_b  (sbc_sel_b),
    .a_new  (alu_a),
    .b_new  (alu_b),
    .x_new  (alu_x),
    .cc_new (alu_cc)
  );

  // ------------------------------------------------------------
  // register file next values
  // ------------------------------------------------------------
  wire logic [3:0] ea_dst = {2'b00, idx_sel} + RC_X;
  wire logic       idx_wr = ea_op && auto_mod;
  wire logic [15:0] ab_sw = put(RC_D, d_val);
  wire logic [7:0] a_nxt  = alu_op ? alu_a : 8'(put(RC_A, {8'h00, ab_sw[15:8]}));
  wire logic [7:0] b_nxt  = alu_op ? alu_b : 8'(put(RC_B, {8'h00, ab_sw[7:0]}));
  wire logic [7:0] cc_nxt = alu_op ? alu_cc : 8'(put(RC_CC, {8'h00, condition_code_register}));
  wire logic [7:0] dp_nxt = 8'(put(RC_DP, {8'h00, direct_page_register}));
  wire logic [15:0] x_nxt = alu_op ? alu_x :
                            (idx_wr && ea_dst == RC_X) ? idx_new : put(RC_X, x_r);
  wire logic [15:0] y_nxt = (idx_wr && ea_dst == RC_Y) ? idx_new : put(RC_Y, y_r);
  wire logic [15:0] u_nxt = (idx_wr && ea_dst == RC_U) ? idx_new : put(RC_U, u_r);
  wire logic [15:0] s_nxt = (idx_wr && ea_dst == RC_S) ? idx_new : put(RC_S, s_r);
  wire logic [15:0] pc_nxt = put(RC_PC, pc_r);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_a_r <= 8'h00;
      acc_b_r <= 8'h00;
      condition_code_register <= RESET_CC;
      direct_page_register <= 8'h00;
      {x_r, y_r, u_r, s_r} <= {4{16'h0000}};
      pc_r <= RESET_PC;
      ea_r <= 16'h0000;
    end else begin
      acc_a_r <= a_nxt;
      acc_b_r <= b_nxt;
      condition_code_register <= cc_nxt;
      direct_page_register <= dp_nxt;
      {x_r, y_r, u_r, s_r} <= {x_nxt, y_nxt, u_nxt, s_nxt};
      pc_r <= pc_nxt;
      if (ea_op) ea_r <= ea_calc;
    end
  end

  // ------------------------------------------------------------
  // stack push selection
  // ------------------------------------------------------------
  wire logic push_op = run_op && (op_code == OP_PUSH_S || op_code == OP_PUSH_U);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      push_select_r <= 8'h00;
      push_sp_value_r <= 16'h0000;
      push_busy_r <= 1'b0;
      xfer_reject_r <= 1'b0;
    end else begin
      push_busy_r <= push_op;
      xfer_reject_r <= xfer_op && !xfer_ok && !waiting;
      if (push_op) begin
        push_select_r <= post_byte;
        // the other-pointer slot carries the opposite stack, never its own
        push_sp_value_r <= (op_code == OP_PUSH_S) ? u_r : s_r;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt inputs and wait state
  // ------------------------------------------------------------
  logic irq_meta_r, irq_sync_r, fast_interrupt_request_meta_r, fast_interrupt_request_sync_r;
  logic [1:0] low_cnt_r;
  run_state_t state_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {irq_meta_r, irq_sync_r, fast_interrupt_request_meta_r, fast_interrupt_request_sync_r} <= 4'hF;
    end else begin
      irq_meta_r <= irq_n;
      irq_sync_r <= irq_meta_r;
      fast_interrupt_request_meta_r <= fast_interrupt_request_n;
      fast_interrupt_request_sync_r <= fast_interrupt_request_meta_r;
    end
  end

  wire logic irq_low    = !irq_sync_r;
  wire logic fast_interrupt_request_low   = !fast_interrupt_request_sync_r;
  wire logic unmasked   = (irq_low && !condition_code_register[CC_I]) ||
                          (fast_interrupt_request_low && !condition_code_register[CC_F]);
  wire logic any_low    = irq_low || fast_interrupt_request_low;
  // level inputs: while running, only three consecutive unmasked low samples are honoured; in the wait state one low sample wakes
  wire logic accept     = unmasked && (low_cnt_r == ACCEPT_CYCLES - 2'h1);
  wire logic wake       = (state_r == ST_WAIT) && any_low;
  wire logic masked_cyc = (state_r == ST_RUN) && any_low && !unmasked;
  assign waiting = (state_r == ST_WAIT);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_RUN;
      low_cnt_r <= 2'h0;
      int_take_r <= 1'b0;
      resume_next_r <= 1'b0;
      masked_fetch_r <= 1'b0;
      fetch_addr_r <= 16'h0000;
    end else begin
      low_cnt_r <= !unmasked ? 2'h0 : accept ? low_cnt_r : low_cnt_r + 2'h1;
      int_take_r <= (wake && unmasked) || (state_r == ST_RUN && accept);
      resume_next_r <= wake && !unmasked;
      masked_fetch_r <= masked_cyc;
      if (masked_cyc || (wake && !unmasked)) fetch_addr_r <= pc_r + 16'h0001;
      case (state_r)
        ST_RUN:  if (run_op && op_code == OP_WAIT) state_r <= ST_WAIT;
        ST_WAIT: if (any_low) state_r <= ST_RUN;
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wake_one_cycle_a: assert property (waiting && any_low |=> !waiting)
    else $error("wait state not left after one low cycle");
  masked_resume_a: assert property (waiting && any_low && !unmasked |=>
                                    resume_next_r && !int_take_r && fetch_addr_r == $past(pc_r) + 16'h0001)
    else $error("masked wake did not resume at next instruction");
  masked_fetch_a: assert property (!waiting && any_low && !unmasked |=>
                                   masked_fetch_r && !int_take_r)
    else $error("masked request did not become plain fetch");
  accept_three_a: assert property ((!waiting && unmasked) [*3] |-> ##[0:1] int_take_r)
    else $error("unmasked request held three cycles not taken");
  mul_result_a: assert property (run_op && op_code == OP_MUL |=>
                                 {acc_a_r, acc_b_r} == $past(acc_a_r) * $past(acc_b_r))
    else $error("multiply result wrong");
  sex_fill_a: assert property (run_op && op_code == OP_SEX |=>
                               acc_a_r == {8{$past(acc_b_r[7])}})
    else $error("sign extend wrong");
  abx_sum_a: assert property (run_op && op_code == OP_ABX |=>
                              x_r == $past(x_r) + {8'h00, $past(acc_b_r)})
    else $error("add b to x wrong");
  compare_double_accumulator_op_keep_a: assert property (run_op && op_code == OP_COMPARE_DOUBLE_ACCUMULATOR_OP |=> $stable({acc_a_r, acc_b_r}))
    else $error("compare changed accumulator d");
  size_reject_a: assert property (xfer_op && !waiting && !size_ok |=>
                                  xfer_reject_r && $stable(pc_r) && $stable(x_r))
    else $error("mixed size transfer not rejected");
  autodec_ea_a: assert property (ea_op && ea_mode == EA_DEC2 |=>
                                 ea_r == $past(idx_val) - 16'h0002)
    else $error("auto decrement address wrong");
  autoinc_ea_a: assert property (ea_op && ea_mode == EA_INC1 |=> ea_r == $past(idx_val))
    else $error("auto increment address wrong");
  direct_ea_a: assert property (ea_op && ea_mode == EA_DIRECT |=>
                                ea_r == {$past(direct_page_register), $past(operand[7:0])})
    else $error("direct address wrong");

  wake_masked_c: cover property (waiting && any_low && !unmasked);
  wake_taken_c: cover property (waiting && any_low && unmasked);
  swap_c: cover property (xfer_go && swap_op && !src_code[RC_SIZE_BIT]);
  push_c: cover property (push_op && post_byte[PB_OTHER_SP]);
endmodule : cpu_instruction_execution

// *** design/cpu_exec_pkg.sv ***
// shared constants and types for the instruction execution block
package cpu_exec_pkg;

  typedef enum logic [3:0] {
    OP_NONE, OP_EA, OP_MUL, OP_SEX, OP_ABX, OP_DAA, OP_SBC, OP_COMPARE_DOUBLE_ACCUMULATOR_OP,
    OP_SWAP, OP_COPY, OP_PUSH_S, OP_PUSH_U, OP_WAIT
  } op_t;

  typedef enum logic [3:0] {
    EA_NO_OFF, EA_OFF5, EA_OFF8, EA_OFF16, EA_ACC_A, EA_ACC_B, EA_ACC_D,
    EA_INC1, EA_INC2, EA_DEC1, EA_DEC2, EA_PC8, EA_PC16, EA_DIRECT, EA_EXTENDED
  } ea_mode_t;

  typedef enum logic {ST_RUN, ST_WAIT} run_state_t;

  // condition code bit positions
  localparam int CC_E = 7;
  localparam int CC_F = 6;
  localparam int CC_H = 5;
  localparam int CC_I = 4;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;

  // register field codes of the swap/copy postbyte
  localparam logic [3:0] RC_D  = 4'h0;
  localparam logic [3:0] RC_X  = 4'h1;
  localparam logic [3:0] RC_Y  = 4'h2;
  localparam logic [3:0] RC_U  = 4'h3;
  localparam logic [3:0] RC_S  = 4'h4;
  localparam logic [3:0] RC_PC = 4'h5;
  localparam logic [3:0] RC_A  = 4'h8;
  localparam logic [3:0] RC_B  = 4'h9;
  localparam logic [3:0] RC_CC = 4'hA;
  localparam logic [3:0] RC_DP = 4'hB;
  localparam int RC_SIZE_BIT = 3;

  // push postbyte: bit 6 names the other stack pointer
  localparam int PB_OTHER_SP = 6;

  // index register selection
  localparam logic [1:0] IX_X = 2'h0;
  localparam logic [1:0] IX_Y = 2'h1;
  localparam logic [1:0] IX_U = 2'h2;
  localparam logic [1:0] IX_S = 2'h3;

  localparam logic [1:0] ACCEPT_CYCLES = 2'h3;
  localparam logic [7:0] RESET_CC      = 8'h50;
  localparam logic [15:0] RESET_PC     = 16'h0000;

endpackage : cpu_exec_pkg

// *** design/ea_unit.sv ***
// effective address calculator for indexed, relative, direct and extended modes
`timescale 1ns/1ps
module ea_unit
  import cpu_exec_pkg::*;
(
  input  cpu_exec_pkg::ea_mode_t mode,
  input  wire logic [15:0]       index,
  input  wire logic [7:0]        acc_a,
  input  wire logic [7:0]        acc_b,
  input  wire logic [15:0]       pc,
  input  wire logic [7:0]        dp,
  input  wire logic [15:0]       operand,
  output logic [15:0]            ea,
  output logic [15:0]            index_new
);
  wire logic [15:0] off5  = {{11{operand[4]}}, operand[4:0]};
  wire logic [15:0] off8  = {{8{operand[7]}}, operand[7:0]};
  wire logic [15:0] dec1  = index - 16'h0001;
  wire logic [15:0] dec2  = index - 16'h0002;

  always_comb begin
    ea = index;
    index_new = index;
    case (mode)
      EA_NO_OFF:   ea = index;
      EA_OFF5:     ea = index + off5;
      EA_OFF8:     ea = index + off8;
      EA_OFF16:    ea = index + operand;
      EA_ACC_A:    ea = index + {8'h00, acc_a};
      EA_ACC_B:    ea = index + {8'h00, acc_b};
      EA_ACC_D:    ea = index + {acc_a, acc_b};
      EA_INC1:     index_new = index + 16'h0001;
      EA_INC2:     index_new = index + 16'h0002;
      EA_DEC1: begin
        ea = dec1;
        index_new = dec1;
      end
      EA_DEC2: begin
        ea = dec2;
        index_new = dec2;
      end
      EA_PC8:      ea = pc + off8;
      EA_PC16:     ea = pc + operand;
      EA_DIRECT:   ea = {dp, operand[7:0]};
      EA_EXTENDED: ea = operand;
      default:     ea = index;
    endcase
  end
endmodule : ea_unit

// *** design/acc_alu.sv ***
// accumulator arithmetic: multiply, sign extend, add b to x, decimal adjust, borrow, compare
`timescale 1ns/1ps
module acc_alu
  import cpu_exec_pkg::*;
(
  input  cpu_exec_pkg::op_t op,
  input  wire logic [7:0]   a,
  input  wire logic [7:0]   b,
  input  wire logic [15:0]  x,
  input  wire logic [7:0]   cc,
  input  wire logic [15:0]  mem,
  input  wire logic         sel_b,
  output logic [7:0]        a_new,
  output logic [7:0]        b_new,
  output logic [15:0]       x_new,
  output logic [7:0]        cc_new
);
  wire logic [15:0] prod    = {8'h00, a} * {8'h00, b};
  wire logic [7:0]  sbc_acc = sel_b ? b : a;
  wire logic [8:0]  sbc_r   = {1'b0, sbc_acc} - {1'b0, mem[7:0]} - {8'h00, cc[CC_C]};
  wire logic [16:0] cmp_r   = {1'b0, a, b} - {1'b0, mem};
  wire logic        lo_fix  = cc[CC_H] || (a[3:0] > 4'h9);
  wire logic        hi_fix  = cc[CC_C] || (a[7:4] > 4'h9) || ((a[7:4] > 4'h8) && (a[3:0] > 4'h9));
  wire logic [7:0]  daa_add = {hi_fix ? 4'h6 : 4'h0, lo_fix ? 4'h6 : 4'h0};
  wire logic [8:0]  daa_r   = {1'b0, a} + {1'b0, daa_add};

  always_comb begin
    a_new  = a;
    b_new  = b;
    x_new  = x;
    cc_new = cc;
    case (op)
      OP_MUL: begin
        {a_new, b_new} = prod;
        cc_new[CC_Z] = (prod == 16'h0000);
        cc_new[CC_C] = prod[7];
      end
      OP_SEX: begin
        a_new = {8{b[7]}};
        cc_new[CC_N] = b[7];
        cc_new[CC_Z] = ({{8{b[7]}}, b} == 16'h0000);
      end
      OP_ABX: x_new = x + {8'h00, b};
      OP_DAA: begin
        a_new = daa_r[7:0];
        cc_new[CC_N] = daa_r[7];
        cc_new[CC_Z] = (daa_r[7:0] == 8'h00);
        cc_new[CC_C] = cc[CC_C] | daa_r[8];
      end
      OP_SBC: begin
        if (sel_b) b_new = sbc_r[7:0];
        else a_new = sbc_r[7:0];
        cc_new[CC_N] = sbc_r[7];
        cc_new[CC_Z] = (sbc_r[7:0] == 8'h00);
        cc_new[CC_V] = (sbc_acc[7] ^ mem[7]) & (sbc_acc[7] ^ sbc_r[7]);
        cc_new[CC_C] = sbc_r[8];
      end
      OP_COMPARE_DOUBLE_ACCUMULATOR_OP: begin
        cc_new[CC_N] = cmp_r[15];
        cc_new[CC_Z] = (cmp_r[15:0] == 16'h0000);
        cc_new[CC_V] = (a[7] ^ mem[15]) & (a[7] ^ cmp_r[15]);
        cc_new[CC_C] = cmp_r[16];
      end
      default: ;
    endcase
  end
endmodule : acc_alu

// *** dv/int_source.sv ***
// interrupt source model driving the two active-low request lines
`timescale 1ns/1ps
module int_source (
  input  wire logic clk,
  output logic      irq_n,
  output logic      fast_interrupt_request_n
);
  // lines are open-collector with pull-ups: idle and released level is high
  initial begin
    irq_n = 1'b1;
    fast_interrupt_request_n = 1'b1;
  end

  // hold a request low for a number of whole cycles, then let it float high
  task automatic pull(input bit fast, input int cycles);
    @(negedge clk);
    if (fast) fast_interrupt_request_n = 1'b0;
    else irq_n = 1'b0;
    repeat (cycles) @(negedge clk);
    irq_n = 1'b1;
    fast_interrupt_request_n = 1'b1;
  endtask : pull
endmodule : int_source

// *** dv/cpu_instruction_execution_bench.sv ***
// self-checking bench for the execution block against a behavioural model
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module cpu_instruction_execution_bench;
  import cpu_exec_pkg::*;
  logic       clk = 0, reset = 1, op_valid = 0, sbc_sel_b = 0;
  op_t        op_code = OP_NONE;
  ea_mode_t   ea_mode = EA_NO_OFF;
  logic [1:0] idx_sel = 2'h0;
  logic [7:0] post_byte = 8'h00, acc_a_r, acc_b_r, condition_code_register;
  logic [7:0] direct_page_register, push_select_r, pb;
  logic [15:0] operand = 16'h0000, mem_data = 16'h0000, x_r, y_r, u_r, s_r, pc_r;
  logic [15:0] ea_r, fetch_addr_r, push_sp_value_r, e, m;
  logic       masked_fetch_r, int_take_r, resume_next_r, waiting, xfer_reject_r, push_busy_r;
  wire        irq_n, fast_interrupt_request_n;
  int         err_total = 0, checks_done = 0;
  int         p, q;
  // ------------------------------------------------------------
  // model state
  // ------------------------------------------------------------
  logic [7:0] a = 0, b = 0, dp = 0;
  logic [15:0] x = 0, u = 0, s = 0, pc = 0;
  logic       c = 0;
  logic [8:0] s9;

  always #20 clk = ~clk;

  cpu_instruction_execution cpu_instruction_execution_inst (.clk, .reset, .op_valid, .op_code,
    .ea_mode, .idx_sel, .post_byte, .operand, .mem_data, .sbc_sel_b, .irq_n,
    .fast_interrupt_request_n, .acc_a_r, .acc_b_r, .condition_code_register,
    .direct_page_register, .x_r, .y_r, .u_r, .s_r, .pc_r, .ea_r, .fetch_addr_r,
    .masked_fetch_r, .int_take_r, .resume_next_r, .waiting, .xfer_reject_r,
    .push_select_r, .push_sp_value_r, .push_busy_r);

  int_source int_source_inst (.clk, .irq_n, .fast_interrupt_request_n);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task test_done;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // op_valid stays up so back-to-back ops never toggle it within one step
  task op(input op_t o, input logic [7:0] p, input logic [15:0] v, input logic sb);
    op_valid = 1'b1;
    op_code = o;
    post_byte = p;
    operand = v;
    mem_data = v;
    sbc_sel_b = sb;
    @(negedge clk);
  endtask : op

  task idle;
    op_valid = 1'b0;
    @(negedge clk);
  endtask : idle

  function logic flag(input int w);
    return (w == 0) ? masked_fetch_r : (w == 1) ? resume_next_r : int_take_r;
  endfunction : flag

  task wait_flag(input int w);
    int n;
    n = 0;
    while (n < 20 && flag(w) !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) begin
      err_total++;
      test_done();
    end
  endtask : wait_flag

  task sbc(input logic sb, input logic [7:0] mv);
    s9 = {1'b0, sb ? b : a} - {1'b0, mv} - {8'h00, c};
    op(OP_SBC, 8'h00, {8'h00, mv}, sb);
    c = s9[8];
    if (sb) b = s9[7:0];
    else a = s9[7:0];
    `CHK({condition_code_register[CC_C], acc_a_r, acc_b_r}, {c, a, b})
  endtask : sbc

  function automatic logic [15:0] ea_of(input int k, input logic [15:0] v);
    case (k)
      1: return x + {{11{v[4]}}, v[4:0]};
      2: return x + {{8{v[7]}}, v[7:0]};
      3: return x + v;
      4: return x + {8'h00, a};
      5: return x + {8'h00, b};
      6: return x + {a, b};
      9: return x - 16'h0001;
      10: return x - 16'h0002;
      11: return pc + {{8{v[7]}}, v[7:0]};
      12: return pc + v;
      14: return v;
      13: return {dp, v[7:0]};
      default: return x;
    endcase
  endfunction : ea_of

  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : bcd

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(6));
    repeat (8) @(negedge clk);
    reset = 1'b0;
    int_source_inst.pull(0, 1);
    wait_flag(0);
    `CHK(fetch_addr_r, 16'h0001)
    op(OP_WAIT, 8'h00, 16'h0000, 1'b0);
    idle();
    `CHK(waiting, 1'b1)
    int_source_inst.pull(0, 1);
    wait_flag(1);
    `CHK({waiting, fetch_addr_r}, {1'b0, 16'h0001})
    for (int i = 0; i < 8; i++) begin
      sbc(1'b0, 8'($urandom));
      sbc(1'b1, 8'($urandom));
      op(OP_MUL, 8'h00, 16'h0000, 1'b0);
      {a, b} = a * b;
      c = b[7];
      `CHK({condition_code_register[CC_C], acc_a_r, acc_b_r}, {c, a, b})
      op(OP_COMPARE_DOUBLE_ACCUMULATOR_OP, 8'h00, {a, b}, 1'b0);
      c = 1'b0;
      `CHK({condition_code_register[CC_Z], condition_code_register[CC_C], acc_a_r, acc_b_r}, {1'b1, c, a, b})
      op(OP_SEX, 8'h00, 16'h0000, 1'b0);
      a = {8{b[7]}};
      `CHK(acc_a_r, a)
      op(OP_ABX, 8'h00, 16'h0000, 1'b0);
      x = x + {8'h00, b};
      `CHK(x_r, x)
      op(OP_COPY, 8'h05, 16'h0000, 1'b0);
      pc = {a, b};
      `CHK(pc_r, pc)
      for (int k = 0; k < 15; k++) begin
        ea_mode = ea_mode_t'(k[3:0]);
        m = 16'($urandom);
        e = ea_of(k, m);
        op(OP_EA, 8'h00, m, 1'b0);
        `CHK(ea_r, e)
        if (k == 7 || k == 8) x = x + 16'(k - 6);
        if (k == 9 || k == 10) x = e;
        `CHK(x_r, x)
      end
      op(OP_COPY, 8'h04, 16'h0000, 1'b0);
      s = {a, b};
      op(OP_SWAP, 8'h01, 16'h0000, 1'b0);
      {a, b, x} = {x, a, b};
      `CHK({acc_a_r, acc_b_r, x_r, s_r}, {a, b, x, s})
      op(OP_COPY, 8'h01, 16'h0000, 1'b0);
      x = {a, b};
      `CHK(x_r, x)
      op(OP_COPY, 8'h8B, 16'h0000, 1'b0);
      dp = a;
      `CHK(direct_page_register, dp)
      op(OP_COPY, 8'h18, 16'h0000, 1'b0);
      `CHK({xfer_reject_r, acc_a_r}, {1'b1, a})
      op(OP_COPY, 8'h03, 16'h0000, 1'b0);
      u = {a, b};
      pb = 8'($urandom);
      op(OP_PUSH_S, pb, 16'h0000, 1'b0);
      `CHK({push_select_r, push_sp_value_r}, {pb, u})
      op(OP_PUSH_U, pb, 16'h0000, 1'b0);
      `CHK({push_busy_r, push_sp_value_r}, {1'b1, s})
    end
    // unmask both requests by copying a zeroed accumulator into the flags
    sbc(1'b0, a - {7'h00, c});
    op(OP_COPY, 8'h8A, 16'h0000, 1'b0);
    c = 1'b0;
    `CHK(condition_code_register, 8'h00)
    // packed decimal sums: flags staged through a, the sum parked in b then copied to a
    for (int i = 0; i < 4; i++) begin
      p = $urandom % 100;
      q = $urandom % 100;
      e = {8'h00, bcd(p)} + {8'h00, bcd(q)};
      pb = {2'b00, ((p % 10) + (q % 10)) > 15, 4'h0, e[8]};
      sbc(1'b1, b - e[7:0] - {7'h00, c});
      sbc(1'b0, a - pb - {7'h00, c});
      op(OP_COPY, 8'h8A, 16'h0000, 1'b0);
      c = pb[0];
      `CHK(condition_code_register, pb)
      op(OP_COPY, 8'h98, 16'h0000, 1'b0);
      a = b;
      `CHK(acc_a_r, a)
      op(OP_DAA, 8'h00, 16'h0000, 1'b0);
      a = bcd((p + q) % 100);
      c = (p + q) > 99;
      `CHK({condition_code_register[CC_C], acc_a_r}, {c, a})
    end
    idle();
    int_source_inst.pull(1, 3);
    wait_flag(2);
    `CHK(int_take_r, 1'b1)
    op(OP_WAIT, 8'h00, 16'h0000, 1'b0);
    idle();
    int_source_inst.pull(0, 1);
    wait_flag(2);
    `CHK(waiting, 1'b0)
    test_done();
  end
endmodule : cpu_instruction_execution_bench
